// ---- design/rts_clk.sv ----
`timescale 1ns/1ps
// residual timestamp generation and recovery with shared network divider
`include "rts_map.svh"
module rts_clk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire rts_pkg::rts_apb_req_t apb_req,
   output rts_pkg::rts_apb_rsp_t apb_rsp,
   input wire logic network_reference_pin,
   input wire logic backplane_bit_clock,
   input wire logic [`RTS_NPORT-1:0] line_input_clock,
   input wire logic [`RTS_NPORT-1:0] recovered_pll_clock,
   input wire logic [`RTS_NPORT-1:0] tx_req,
   input wire rts_pkg::rts_rxw_t [`RTS_NPORT-1:0] rx_wr,
   input wire logic [`RTS_NPORT-1:0] pll_req,
   output logic ref_8k,
   output rts_pkg::rts_tx_t [`RTS_NPORT-1:0] tx_out,
   output rts_pkg::rts_pll_t [`RTS_NPORT-1:0] pll_out
);
   import rts_pkg::*;
   rts_st_t s, next_s;
   logic [`RTS_NSYNC-1:0] edg;
   logic [`RTS_NPORT-1:0] tclk;
   logic [`RTS_NPORT-1:0] txp;
   logic [`RTS_NPORT-1:0] rxp;

   // edges only from the second synchroniser stage
   assign edg = s.s2 & ~s.prv;

   genvar g;
   generate
      for (g = 0; g < `RTS_NPORT; g++) begin : gp
         // segmentation clock from line input or backplane
         assign tclk[g] = s.port[g].cfg.bp_src ? edg[1] : edg[2 + g];
         // transmit generator, held off for signalling circuits
         rts_gen u_txg (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .clk_pulse(tclk[g]),
            .en(~s.port[g].cfg.cas),
            .structured_transport(s.port[g].cfg.structured_transport),
            .chans(s.port[g].cfg.chans),
            .rts_pulse(txp[g])
         );
         // reassembly generator on the recovered clock
         rts_gen u_rxg (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .clk_pulse(edg[2 + `RTS_NPORT + g]),
            .en(~s.port[g].cfg.cas),
            .structured_transport(s.port[g].cfg.structured_transport),
            .chans(s.port[g].cfg.chans),
            .rts_pulse(rxp[g])
         );
         assign tx_out[g] = s.port[g].tx;
         assign pll_out[g] = s.port[g].pll;
      end
   endgenerate

   always_comb begin
      logic setup;
      logic wacc;
      logic hit;
      logic pushok;
      logic popok;
      logic inval;
      logic holdn;
      logic [3:0] fv;
      logic [5:0] ent;
      logic [7:0] pa;
      logic [7:0] sa;
      logic [`RTS_CLR_W-1:0] clr;
      rts_pstat_t set;
      rts_pcfg_t wc;
      setup = 1'b0;
      wacc = 1'b0;
      hit = 1'b0;
      pushok = 1'b0;
      popok = 1'b0;
      inval = 1'b0;
      holdn = 1'b0;
      fv = 4'h0;
      ent = 6'h0;
      pa = 8'h0;
      sa = 8'h0;
      clr = '0;
      set = '0;
      wc = '0;
      next_s = s;

      // pins pass two flops before any logic looks at them
      next_s.s1 = {recovered_pll_clock, line_input_clock, backplane_bit_clock,
                   network_reference_pin};
      next_s.s2 = s.s1;
      next_s.prv = s.s2;

      // one divider chain and three 4-bit counters for all ports
      if (edg[0]) begin
         next_s.ndiv = s.ndiv + 3'h1;
         if (s.ndiv == `RTS_UDT_LAST) begin
            next_s.fnx[0] = s.fnx[0] + 4'h1;
         end
         // two structured rates, divisor zero counts as 256
         if (s.adiv >= s.sdiv_a - 8'h1) begin
            next_s.adiv = 8'h0;
            next_s.fnx[1] = s.fnx[1] + 4'h1;
         end else begin
            next_s.adiv = s.adiv + 8'h1;
         end
         if (s.bdiv >= s.sdiv_b - 8'h1) begin
            next_s.bdiv = 8'h0;
            next_s.fnx[2] = s.fnx[2] + 4'h1;
         end else begin
            next_s.bdiv = s.bdiv + 8'h1;
         end
         // 8 kHz reference, half period per toggle
         if (s.k8 == `RTS_K8_LAST) begin
            next_s.k8 = 11'h0;
            next_s.r8k = ~s.r8k;
         end else begin
            next_s.k8 = s.k8 + 11'h1;
         end
      end
      // an 8 kHz pin reference passes straight through
      if (s.ref_direct) begin
         next_s.r8k = s.s2[0];
      end

      // bus: answer one cycle after setup, write at that access edge
      setup = apb_req.psel & ~apb_req.penable;
      wacc = apb_req.psel & apb_req.penable & s.rsp.pready & apb_req.pwrite;
      next_s.rsp.pready = setup;
      if (setup) begin
         next_s.rsp.prdata = 32'h0;
         next_s.rsp.pslverr = 1'b0;
         case (apb_req.paddr)
            `RTS_A_CTRL: begin
               next_s.rsp.prdata = {31'h0, s.ref_direct};
            end
            `RTS_A_SDIVA: begin
               next_s.rsp.prdata = {24'h0, s.sdiv_a};
            end
            `RTS_A_SDIVB: begin
               next_s.rsp.prdata = {24'h0, s.sdiv_b};
            end
            `RTS_A_NET: begin
               next_s.rsp.prdata = {20'h0, s.fnx};
            end
            default: begin
               for (int p = 0; p < `RTS_NPORT; p++) begin
                  pa = `RTS_A_PCFG + 8'(4 * p);
                  sa = `RTS_A_PSTAT + 8'(4 * p);
                  if (apb_req.paddr == pa) begin
                     hit = 1'b1;
                     next_s.rsp.prdata = {19'h0, s.port[p].cfg};
                  end
                  if (apb_req.paddr == sa) begin
                     hit = 1'b1;
                     next_s.rsp.prdata = {27'h0, s.port[p].st};
                  end
               end
               next_s.rsp.pslverr = ~hit;
            end
         endcase
      end
      if (wacc) begin
         case (apb_req.paddr)
            `RTS_A_CTRL: next_s.ref_direct = apb_req.pwdata[0];
            `RTS_A_SDIVA: next_s.sdiv_a = apb_req.pwdata[7:0];
            `RTS_A_SDIVB: next_s.sdiv_b = apb_req.pwdata[7:0];
            default: begin
            end
         endcase
      end

      for (int p = 0; p < `RTS_NPORT; p++) begin
         set = '0;
         clr = '0;
         pa = `RTS_A_PCFG + 8'(4 * p);
         sa = `RTS_A_PSTAT + 8'(4 * p);
         if (wacc && apb_req.paddr == pa) begin
            wc = rts_pcfg_t'(apb_req.pwdata[`RTS_PCFG_W-1:0]);
            wc.rsv = 2'h0;
            // channel count never passes a full line
            if (wc.chans > `RTS_CHANS_MAX) begin
               wc.chans = `RTS_CHANS_MAX;
            end
            next_s.port[p].cfg = wc;
         end
         if (wacc && apb_req.paddr == sa) begin
            clr = apb_req.pwdata[`RTS_CLR_W-1:0];
         end

         // unstructured counter or one of the two structured ones
         if (!s.port[p].cfg.structured_transport) begin
            fv = s.fnx[0];
         end else if (s.port[p].cfg.cnt_sel) begin
            fv = s.fnx[2];
         end else begin
            fv = s.fnx[1];
         end

         // one nibble per engine request, once per eight cells
         next_s.port[p].tx.vld = 1'b0;
         popok = tx_req[p] & (s.port[p].txc != 3'h0);
         if (tx_req[p] && !popok) begin
            set.tx_unr = 1'b1;
         end
         if (popok) begin
            next_s.port[p].tx = {1'b1, s.port[p].txm[s.port[p].txr]};
            next_s.port[p].txr = s.port[p].txr + 2'h1;
         end
         // period pulse stores the counter value
         pushok = txp[p] & ((s.port[p].txc != `RTS_TX_DEPTH) | popok);
         // write to a full FIFO without a same-cycle read is an overflow, value dropped
         if (txp[p] && !pushok) begin
            set.tx_ovf = 1'b1;
         end
         if (pushok) begin
            next_s.port[p].txm[s.port[p].txw] = fv;
            next_s.port[p].txw = s.port[p].txw + 2'h1;
         end
         next_s.port[p].txc = s.port[p].txc + {2'h0, pushok} - {2'h0, popok};

         // reassembly local value for the PLL comparison
         if (rxp[p]) begin
            next_s.port[p].loc = fv;
         end

         // every request answers with the next slot
         next_s.port[p].pll.ack = 1'b0;
         holdn = s.port[p].hold;
         if (pll_req[p]) begin
            ent = s.port[p].rxm[s.port[p].rxr];
            // a read slot is invalid from now on
            next_s.port[p].rxm[s.port[p].rxr] = 6'h0;
            next_s.port[p].rxr = s.port[p].rxr + 2'h1;
            inval = ~ent[5];
            // reading an empty slot is an underrun
            set.rx_unr = inval;
            // invalid read forces holdover, good read releases it
            holdn = inval | (s.port[p].hold & ent[4]);
            next_s.port[p].pll.ack = 1'b1;
            // error entry or holdover: both values unusable
            next_s.port[p].pll.vld = ~holdn & ~ent[4] & ~s.port[p].cfg.hold_force;
            next_s.port[p].pll.loc = s.port[p].loc;
            next_s.port[p].pll.nib = ent[3:0];
         end
         // software holdover overrides the timestamp input
         if (s.port[p].cfg.hold_force) begin
            holdn = 1'b1;
         end
         next_s.port[p].hold = holdn;
         next_s.port[p].pll.hold = holdn;

         // five-bit entries from the reassembly engine
         if (rx_wr[p].wr) begin
            // unread slot means overflow, entry dropped
            if (next_s.port[p].rxm[s.port[p].rxw][5]) begin
               set.rx_ovf = 1'b1;
            end else begin
               next_s.port[p].rxm[s.port[p].rxw] = {1'b1, rx_wr[p].err, rx_wr[p].nib};
               next_s.port[p].rxw = s.port[p].rxw + 2'h1;
            end
         end

         // sticky flags, a new event beats a clear
         next_s.port[p].st[`RTS_CLR_W-1:0] = (s.port[p].st[`RTS_CLR_W-1:0] & ~clr)
                                            | set[`RTS_CLR_W-1:0];
         next_s.port[p].st.hold = holdn;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign apb_rsp = s.rsp;
   assign ref_8k = s.r8k;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_udt_rate: assert property (
      ce && edg[0] && s.ndiv == `RTS_UDT_LAST |=> s.fnx[0] == $past(s.fnx[0]) + 4'h1)
      else $error("unstructured counter did not step");
   a_ref_toggle: assert property (
      ce && edg[0] && !s.ref_direct && s.k8 == `RTS_K8_LAST |=> ref_8k != $past(ref_8k))
      else $error("8 kHz reference did not toggle");
   a_tx_ovf_flag: assert property (
      ce && txp[0] && !tx_req[0] && s.port[0].txc == `RTS_TX_DEPTH
      |=> s.port[0].st.tx_ovf && s.port[0].txc == `RTS_TX_DEPTH)
      else $error("transmit overflow not flagged");
   a_tx_unr_flag: assert property (
      ce && tx_req[0] && s.port[0].txc == 3'h0 |=> s.port[0].st.tx_unr && !tx_out[0].vld)
      else $error("transmit underrun not flagged");
   a_rx_inval_hold: assert property (
      ce && pll_req[0] && !s.port[0].rxm[s.port[0].rxr][5]
      |=> pll_out[0].ack && pll_out[0].hold && !pll_out[0].vld && s.port[0].st.rx_unr)
      else $error("invalid read did not force holdover");
   a_err_drop: assert property (
      ce && pll_req[0] && s.port[0].rxm[s.port[0].rxr][4] |=> !pll_out[0].vld)
      else $error("errored entry passed as valid");
   a_hold_ignore: assert property (
      ce && pll_req[0] && s.port[0].cfg.hold_force |=> pll_out[0].hold && !pll_out[0].vld)
      else $error("input used during holdover");
   a_rate_a_step: assert property (
      ce && edg[0] && s.adiv >= s.sdiv_a - 8'h1
      |=> s.adiv == 8'h0 && s.fnx[1] == $past(s.fnx[1]) + 4'h1)
      else $error("structured rate A did not step");
   a_rate_b_step: assert property (
      ce && edg[0] && s.bdiv >= s.sdiv_b - 8'h1
      |=> s.bdiv == 8'h0 && s.fnx[2] == $past(s.fnx[2]) + 4'h1)
      else $error("structured rate B did not step");
   a_ref_direct: assert property (
      ce && s.ref_direct |=> ref_8k == $past(s.s2[0]))
      else $error("direct 8 kHz reference not passed");
   a_tx_pop_data: assert property (
      ce && tx_req[0] && s.port[0].txc != 3'h0
      |=> tx_out[0].vld && tx_out[0].nib == $past(s.port[0].txm[s.port[0].txr]))
      else $error("transmit nibble not handed over");
   a_tx_push: assert property (
      ce && txp[0] && !tx_req[0] && s.port[0].txc != `RTS_TX_DEPTH
      |=> s.port[0].txc == $past(s.port[0].txc) + 3'h1)
      else $error("timestamp not stored");
   a_rx_ovf_flag: assert property (
      ce && rx_wr[0].wr && !pll_req[0] && s.port[0].rxm[s.port[0].rxw][5]
      |=> s.port[0].st.rx_ovf && s.port[0].rxw == $past(s.port[0].rxw))
      else $error("receive overflow not flagged");
   a_rx_advance: assert property (
      ce && pll_req[0] |=> s.port[0].rxr == $past(s.port[0].rxr) + 2'h1)
      else $error("read pointer did not advance");
   a_pll_ack: assert property (
      ce |=> pll_out[0].ack == $past(pll_req[0]))
      else $error("pll request not acknowledged");
endmodule

// ---- design/rts_gen.sv ----
`timescale 1ns/1ps
// gapping accumulator and payload-bit divider of one timestamp generator
`include "rts_map.svh"
module rts_gen (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic clk_pulse,
   input wire logic en,
   input wire logic structured_transport,
   input wire logic [5:0] chans,
   output logic rts_pulse
);
   import rts_pkg::*;
   rts_gen_st_t s, next_s;
   logic [5:0] nch;
   logic [5:0] sum;
   logic [11:0] last;
   logic bitp;

   always_comb begin
      next_s = s;
      next_s.pulse = 1'b0;
      // zero channels reads as a full line
      nch = (chans == 6'h0) ? `RTS_CHANS_MAX : chans;
      // modulo-32 accumulator, carry gaps the line clock
      sum = {1'b0, s.acc} + nch;
      bitp = structured_transport ? sum[5] : 1'b1;
      last = structured_transport ? `RTS_SDT_BITS_LAST : `RTS_UDT_BITS_LAST;
      if (!en) begin
         next_s.acc = 5'h0;
         next_s.cnt = 12'h0;
      end else if (clk_pulse) begin
         next_s.acc = sum[4:0];
         if (bitp) begin
            if (s.cnt == last) begin
               next_s.cnt = 12'h0;
               next_s.pulse = 1'b1;
            end else begin
               next_s.cnt = s.cnt + 12'h1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign rts_pulse = s.pulse;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_period_end: assert property (
      ce && en && clk_pulse && bitp && s.cnt == last |=> rts_pulse && s.cnt == 12'h0)
      else $error("timestamp period pulse missing");
   a_cas_silent: assert property (
      ce && !en |=> !rts_pulse && s.cnt == 12'h0)
      else $error("generator ran while disabled");
   a_carry_full: assert property (
      ce && en && structured_transport && clk_pulse && nch == 6'h20 && s.cnt != last
      |=> s.cnt == $past(s.cnt) + 12'h1)
      else $error("full-line carry did not count");
endmodule

// ---- design/rts_map.svh ----
// register map, field limits and counts of the residual timestamp block
// Overview of operation
// - one shared divider derives the network clock from the 19.44 MHz reference pin
// - unstructured transport uses a single 2.430 MHz network rate for all ports
// - structured transport supports two channel-count rates, each from 1 to 32 channels
// - the divider also makes an 8 kHz reference for the port PLLs
// - each transmit generator produces 4-bit residual time stamps for the segmentation engine
// - the 4-bit network counters, their dividers and the 8 kHz reference exist once; the rest is per port
// - segmentation local clock is the line input clock or the backplane bit clock
// - reassembly generator runs on the recovered PLL clock and feeds the receive side
// - transmit FIFO flags underrun and overflow in software-readable status bits
// - unstructured mode divides the local clock by 3008 and samples the counter
// - one FIFO value goes to the segmentation engine per eight-cell sequence
// - structured mode adds N per line clock modulo 32; carry is the bit clock
// - N stays within 24 for DS1, 30 for E1, 32 for the bus format; the config write only clamps N to 32, for every line
// - timestamps are not generated for structured circuits carrying signalling
// - each received entry is a 4-bit nibble plus an error bit
// - an entry with its error bit set is discarded together with the local value
// - each PLL request returns the next stored nibble with a validity indication
// - receive FIFO flags underrun and overflow in two status bits
// - a read marks its slot invalid; reading an invalid slot forces holdover
// - during holdover the PLL ignores its timestamp input
`ifndef RTS_MAP_SVH
`define RTS_MAP_SVH
`define RTS_NPORT 2
`define RTS_NSYNC 6
`define RTS_TX_DEPTH 3'h4
`define RTS_RX_DEPTH 4
`define RTS_UDT_LAST 3'h7
`define RTS_K8_LAST 11'h4be
`define RTS_UDT_BITS_LAST 12'hbbf
`define RTS_SDT_BITS_LAST 12'hbb7
`define RTS_CHANS_MAX 6'h20
`define RTS_A_CTRL 8'h00
`define RTS_A_SDIVA 8'h04
`define RTS_A_SDIVB 8'h08
`define RTS_A_NET 8'h0c
`define RTS_A_PCFG 8'h10
`define RTS_A_PSTAT 8'h20
`define RTS_PCFG_W 13
`define RTS_CLR_W 4
`endif

// ---- design/rts_pkg.sv ----
// types of the residual timestamp block
`include "rts_map.svh"
package rts_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } rts_apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } rts_apb_rsp_t;
   typedef struct packed {
      logic cnt_sel;
      logic hold_force;
      logic cas;
      logic bp_src;
      logic structured_transport;
      logic [1:0] rsv;
      logic [5:0] chans;
   } rts_pcfg_t;
   typedef struct packed {
      logic hold;
      logic rx_ovf;
      logic rx_unr;
      logic tx_ovf;
      logic tx_unr;
   } rts_pstat_t;
   typedef struct packed {
      logic vld;
      logic [3:0] nib;
   } rts_tx_t;
   typedef struct packed {
      logic wr;
      logic err;
      logic [3:0] nib;
   } rts_rxw_t;
   typedef struct packed {
      logic ack;
      logic vld;
      logic hold;
      logic [3:0] loc;
      logic [3:0] nib;
   } rts_pll_t;
   typedef struct packed {
      logic pulse;
      logic [4:0] acc;
      logic [11:0] cnt;
   } rts_gen_st_t;
   typedef struct packed {
      rts_pcfg_t cfg;
      rts_pstat_t st;
      logic [3:0][3:0] txm;
      logic [1:0] txw;
      logic [1:0] txr;
      logic [2:0] txc;
      logic [`RTS_RX_DEPTH-1:0][5:0] rxm;
      logic [1:0] rxw;
      logic [1:0] rxr;
      logic [3:0] loc;
      logic hold;
      rts_tx_t tx;
      rts_pll_t pll;
   } rts_port_st_t;
   typedef struct packed {
      logic [`RTS_NSYNC-1:0] s1;
      logic [`RTS_NSYNC-1:0] s2;
      logic [`RTS_NSYNC-1:0] prv;
      logic ref_direct;
      logic [7:0] sdiv_a;
      logic [7:0] sdiv_b;
      logic [7:0] adiv;
      logic [7:0] bdiv;
      logic [2:0] ndiv;
      logic [10:0] k8;
      logic r8k;
      logic [2:0][3:0] fnx;
      rts_apb_rsp_t rsp;
      rts_port_st_t [`RTS_NPORT-1:0] port;
   } rts_st_t;
endpackage

// ---- tb/rts_clk_test.sv ----
`timescale 1ns/1ps
// self-checking bench of the residual timestamp block
`include "rts_map.svh"
module rts_clk_test;
   import rts_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   rts_apb_req_t apb_req = '0;
   rts_apb_rsp_t apb_rsp;
   logic ref_pin = 1'b0;
   logic [`RTS_NPORT-1:0] line_clk = '0;
   logic bp_clk = 1'b0;
   logic [`RTS_NPORT-1:0] pll_clk = '0;
   logic [`RTS_NPORT-1:0] tx_req;
   rts_rxw_t [`RTS_NPORT-1:0] rx_wr;
   logic [`RTS_NPORT-1:0] pll_req;
   logic ref_8k;
   rts_tx_t [`RTS_NPORT-1:0] tx_out;
   rts_pll_t [`RTS_NPORT-1:0] pll_out;
   logic [31:0] q;
   logic e;
   rts_tx_t t;
   rts_pll_t r;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   always #25 pclk = ~pclk;
   rts_clk i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .network_reference_pin(ref_pin), .backplane_bit_clock(bp_clk),
      .line_input_clock(line_clk), .recovered_pll_clock(pll_clk), .tx_req(tx_req),
      .rx_wr(rx_wr), .pll_req(pll_req), .ref_8k(ref_8k), .tx_out(tx_out),
      .pll_out(pll_out));
   rts_far i_far (.pclk(pclk), .tx_out(tx_out), .pll_out(pll_out), .tx_req(tx_req),
      .rx_wr(rx_wr), .pll_req(pll_req));
   task automatic end_sim;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // master holds the request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (apb_rsp.pready !== 1'b1);
      chk(n, 32'h1, "apb wait states");
      q = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   // slow clocks: sel 0 the reference pin, 1 the line inputs, 2 backplane and pll; period 6
   task automatic tick(input int sel, input int n);
      repeat (n) begin
         @(posedge pclk);
         if (sel == 0) ref_pin <= 1'b1;
         else if (sel == 1) line_clk <= '1;
         else {bp_clk, pll_clk} <= '1;
         repeat (3) @(posedge pclk);
         if (sel == 0) ref_pin <= 1'b0;
         else if (sel == 1) line_clk <= '0;
         else {bp_clk, pll_clk} <= '0;
         repeat (2) @(posedge pclk);
      end
   endtask
   task automatic do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task automatic t_regs;
      apb(0, `RTS_A_CTRL, '0); chk(q, 0, "ctrl reset");
      apb(0, `RTS_A_PCFG, '0); chk(q, 0, "pcfg reset");
      apb(0, 8'h40, '0); chk({31'h0, e}, 1, "unmapped error"); chk(q, 0, "unmapped data");
      i_far.take(0, t); chk({31'h0, t.vld}, 0, "empty fifo answer");
      apb(0, `RTS_A_PSTAT, '0); chk(q, 32'h1, "tx underrun flag");
      apb(1, `RTS_A_PSTAT, 32'h1);
      apb(0, `RTS_A_PSTAT, '0); chk(q, 0, "tx underrun cleared");
      $display("test regs done");
   endtask
   task automatic t_udt;
      // port 1 carries signalling, so it must stay silent
      apb(1, `RTS_A_PCFG + 8'h04, 32'h400);
      // pin carries the fast reference, never a direct 8 kHz, while timestamps run
      tick(0, 1214);
      chk({31'h0, ref_8k}, 0, "8k before edge 1215");
      tick(0, 1); repeat (8) @(posedge pclk);
      chk({31'h0, ref_8k}, 1, "8k at edge 1215");
      apb(0, `RTS_A_NET, '0); chk(q, 32'h447, "network counters");
      tick(1, 3007);
      i_far.take(0, t); chk({31'h0, t.vld}, 0, "no stamp at 3007");
      tick(1, 1); repeat (8) @(posedge pclk);
      i_far.take(0, t); chk({27'h0, t}, 32'h17, "stamp at 3008");
      i_far.take(1, t); chk({31'h0, t.vld}, 0, "signalling port silent");
      $display("test udt done");
   endtask
   task automatic t_sdt;
      do_reset;
      // 18 channels, within the E1 limit
      apb(1, `RTS_A_PCFG, 32'h112);
      tick(1, 5333);
      i_far.take(0, t); chk({31'h0, t.vld}, 0, "2999 carries");
      tick(1, 1); repeat (8) @(posedge pclk);
      i_far.take(0, t); chk({31'h0, t.vld}, 1, "3000 carries");
      $display("test sdt done");
   endtask
   task automatic t_rx;
      do_reset;
      i_far.put(0, 0, 4'h1); i_far.put(0, 0, 4'h2); i_far.put(0, 1, 4'h3); i_far.put(0, 0, 4'h4);
      i_far.pull(0, r); chk({27'h0, r.ack, r.vld, r.hold, 2'h0}, 32'h18, "read 1");
      chk({28'h0, r.nib}, 32'h1, "nib 1");
      i_far.pull(0, r); chk({28'h0, r.nib}, 32'h2, "nib 2");
      i_far.pull(0, r); chk({29'h0, r.ack, r.vld, r.hold}, 32'h4, "errored discarded");
      i_far.pull(0, r); chk({27'h0, r.vld, r.nib}, 32'h14, "nib 4");
      i_far.pull(0, r); chk({29'h0, r.ack, r.vld, r.hold}, 32'h5, "reread forces hold");
      apb(0, `RTS_A_PSTAT, '0); chk(q & 32'h1c, 32'h14, "rx underrun and hold");
      // reads advance during underrun, so refill every slot before the next read
      for (int i = 6; i < 10; i++) i_far.put(0, 0, 4'(i));
      i_far.pull(0, r); chk({26'h0, r.vld, r.hold, r.nib}, 32'h27, "holdover left");
      i_far.put(0, 0, 4'ha);
      apb(0, `RTS_A_PSTAT, '0); chk(q & 32'h1c, 32'h0c, "rx overflow");
      $display("test rx done");
   endtask
   task automatic t_ext;
      do_reset;
      apb(1, `RTS_A_SDIVA, 32'h3);
      apb(0, `RTS_A_SDIVA, '0);
      chk(q, 32'h3, "divisor readback");
      apb(1, `RTS_A_SDIVB, 32'h5);
      tick(0, 15);
      apb(0, `RTS_A_NET, '0);
      chk(q, 32'h351, "divided rates");
      // full-line structured port on the backplane clock, recovered clock sets local value
      apb(1, `RTS_A_PCFG, 32'h300);
      tick(2, 3000);
      i_far.take(0, t);
      chk({27'h0, t}, 32'h15, "backplane stamp");
      i_far.put(0, 0, 4'h6);
      i_far.pull(0, r);
      chk({23'h0, r.vld, r.loc, r.nib}, 32'h156, "local value");
      apb(1, `RTS_A_PCFG, 32'h800);
      i_far.put(0, 0, 4'h7);
      i_far.pull(0, r);
      chk({29'h0, r.ack, r.vld, r.hold}, 32'h5, "forced holdover");
      // a direct 8 kHz on the pin only once both ports stop timestamping
      apb(1, `RTS_A_PCFG, 32'h400);
      apb(1, `RTS_A_PCFG + 8'h04, 32'h400);
      apb(1, `RTS_A_CTRL, 32'h1);
      tick(0, 1);
      chk({31'h0, ref_8k}, 1, "direct reference high");
      repeat (8) @(posedge pclk);
      chk({31'h0, ref_8k}, 0, "direct reference low");
      $display("test ext done");
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 100000) begin
         failures++;
         $display("MISMATCH at %0t: timeout", $time);
         end_sim;
      end
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_udt;
      t_sdt;
      t_rx;
      t_ext;
      end_sim;
   end
endmodule

// ---- tb/rts_far.sv ----
`timescale 1ns/1ps
// far side model: segmentation engine, reassembly engine and port pll
`include "rts_map.svh"
module rts_far (
   input wire logic pclk,
   input wire rts_pkg::rts_tx_t [`RTS_NPORT-1:0] tx_out,
   input wire rts_pkg::rts_pll_t [`RTS_NPORT-1:0] pll_out,
   output logic [`RTS_NPORT-1:0] tx_req,
   output rts_pkg::rts_rxw_t [`RTS_NPORT-1:0] rx_wr,
   output logic [`RTS_NPORT-1:0] pll_req
);
   import rts_pkg::*;
   initial begin
      tx_req = '0;
      rx_wr = '0;
      pll_req = '0;
   end
   task automatic take(input int p, output rts_tx_t t);
      @(posedge pclk);
      tx_req[p] <= 1'b1;
      @(posedge pclk);
      tx_req[p] <= 1'b0;
      @(negedge pclk);
      t = tx_out[p];
   endtask
   // entry is error flag over nibble; released lines show inverted data
   task automatic put(input int p, input logic err, input logic [3:0] nib);
      @(posedge pclk);
      rx_wr[p] <= '{wr: 1'b1, err: err, nib: nib};
      @(posedge pclk);
      rx_wr[p] <= '{wr: 1'b0, err: ~err, nib: ~nib};
   endtask
   // each request returns nibble with validity
   task automatic pull(input int p, output rts_pll_t r);
      @(posedge pclk);
      pll_req[p] <= 1'b1;
      @(posedge pclk);
      pll_req[p] <= 1'b0;
      @(negedge pclk);
      r = pll_out[p];
   endtask
endmodule
